// ### hdl/tmr_pkg.sv
// package of register map, field positions and encodings for the 16-bit capture/compare timer
`default_nettype none
package tmr_pkg;
	localparam logic [3:0] ADDR_CTRL_A     = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B     = 4'h1;
	localparam logic [3:0] ADDR_CTRL_C     = 4'h2;
	localparam logic [3:0] ADDR_CNT_L      = 4'h4;
	localparam logic [3:0] ADDR_CNT_H      = 4'h5;
	localparam logic [3:0] ADDR_CAP_L      = 4'h6;
	localparam logic [3:0] ADDR_CAP_H      = 4'h7;
	localparam logic [3:0] ADDR_CMPA_L     = 4'h8;
	localparam logic [3:0] ADDR_CMPA_H     = 4'h9;
	localparam logic [3:0] ADDR_CMPB_L     = 4'hA;
	localparam logic [3:0] ADDR_CMPB_H     = 4'hB;
	localparam logic [3:0] ADDR_MASK       = 4'hC;
	localparam logic [3:0] ADDR_FLAGS      = 4'hD;
	localparam logic [3:0] ADDR_GIE        = 4'hE;
	localparam logic [3:0] ADDR_VEC_ACK    = 4'hF;
	localparam int         CB_NOISE_BIT    = 7;
	localparam int         CB_EDGE_BIT     = 6;
	localparam int         CB_RSVD_BIT     = 5;
	localparam int         CC_FORCE_A_BIT  = 7;
	localparam int         CC_FORCE_B_BIT  = 6;
	localparam int         IRQ_CAP_BIT     = 5;
	localparam int         IRQ_CMPB_BIT    = 2;
	localparam int         IRQ_CMPA_BIT    = 1;
	localparam int         IRQ_OVF_BIT     = 0;
	localparam logic [7:0] IRQ_USED_MASK   = 8'h27;
	localparam logic [7:0] CTRL_B_WR_MASK  = 8'hDF;
	localparam logic [7:0] REG8_RESET      = 8'h00;
	localparam logic [15:0] REG16_RESET    = 16'h0000;
	localparam int         FILTER_SAMPLES  = 4;
	localparam logic [15:0] TOP_MAX        = 16'hFFFF;
	localparam logic [9:0] DIV_8_LAST      = 10'h007;
	localparam logic [9:0] DIV_64_LAST     = 10'h03F;
	localparam logic [9:0] DIV_256_LAST    = 10'h0FF;
	localparam logic [9:0] DIV_1024_LAST   = 10'h3FF;
	typedef enum logic [2:0] {
		CS_STOP  = 3'b000,
		CS_DIV1  = 3'b001,
		CS_DIV8  = 3'b010,
		CS_DIV64 = 3'b011,
		CS_DIV256 = 3'b100,
		CS_DIV1024 = 3'b101,
		CS_EXT_FALL = 3'b110,
		CS_EXT_RISE = 3'b111
	} tmr_clk_sel_type;
endpackage
`default_nettype wire

// ### hdl/tmr_capture_filter.sv
// capture pin noise filter and edge detector
`default_nettype none
module tmr_capture_filter
	import tmr_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	input  wire logic pin_in,
	input  wire logic filter_en_in,
	input  wire logic rising_sel_in,
	output logic      event_out
);
	logic [FILTER_SAMPLES-1:0] hist_r;
	logic                      filt_r;
	logic                      level_prev_r;
	logic                      level;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hist_r <= '0;
			filt_r <= 1'b0;
		end else if (ce_in) begin
			hist_r <= {hist_r[FILTER_SAMPLES-2:0], pin_in};
			if (&hist_r || ~|hist_r) begin
				filt_r <= hist_r[0];
			end
		end
	end
	assign level = filter_en_in ? filt_r : hist_r[0];
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			level_prev_r <= 1'b0;
		end else if (ce_in) begin
			level_prev_r <= level;
		end
	end
	assign event_out = rising_sel_in ? (level & ~level_prev_r) : (~level & level_prev_r);
endmodule
`default_nettype wire

// ### hdl/tmr_clock_select.sv
// prescaler and external count pin edge detector producing the timer tick
`default_nettype none
module tmr_clock_select
	import tmr_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	input  wire logic [2:0] sel_in,
	input  wire logic       ext_pin_in,
	output logic            tick_out
);
	logic [9:0] pre_r;
	logic       ext_s_r;
	logic       ext_prev_r;
	tmr_clk_sel_type sel;
	assign sel = tmr_clk_sel_type'(sel_in);
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pre_r <= 10'h000;
		end else if (ce_in) begin
			pre_r <= pre_r + 10'h001;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_s_r    <= 1'b0;
			ext_prev_r <= 1'b0;
		end else if (ce_in) begin
			ext_s_r    <= ext_pin_in;
			ext_prev_r <= ext_s_r;
		end
	end
	always_comb begin
		unique case (sel)
			CS_STOP:     tick_out = 1'b0;
			CS_DIV1:     tick_out = 1'b1;
			CS_DIV8:     tick_out = (pre_r[2:0] == DIV_8_LAST[2:0]);
			CS_DIV64:    tick_out = (pre_r[5:0] == DIV_64_LAST[5:0]);
			CS_DIV256:   tick_out = (pre_r[7:0] == DIV_256_LAST[7:0]);
			CS_DIV1024:  tick_out = (pre_r == DIV_1024_LAST);
			CS_EXT_FALL: tick_out = ext_prev_r & ~ext_s_r;
			CS_EXT_RISE: tick_out = ~ext_prev_r & ext_s_r;
		endcase
	end
endmodule
`default_nettype wire

// ### hdl/tmr_top.sv
// 16-bit timer with input capture, two compare channels and byte register port
`default_nettype none
module tmr_top
	import tmr_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	input  wire logic [3:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic [7:0]      rdata_out,
	input  wire logic       capture_input_pin_in,
	input  wire logic       comparator_in,
	input  wire logic       external_count_pin_in,
	output logic            wave_out_chan_a_out,
	output logic            wave_out_chan_b_out,
	output logic            capture_irq_out,
	output logic            compare_a_irq_out,
	output logic            compare_b_irq_out,
	output logic            overflow_irq_out
);
	logic        rst_s1_r;
	logic        rst_n_r;
	logic [7:0]  ctrl_a_r;
	logic [7:0]  ctrl_b_r;
	logic [15:0] counter_value_r;
	logic [15:0] compare_value_a_r;
	logic [15:0] compare_value_b_r;
	logic [15:0] capture_value_r;
	logic [7:0]  temp_r;
	logic [7:0]  mask_r;
	logic [7:0]  flags_r;
	logic        gie_r;
	logic        block_r;
	logic        up_r;
	logic        wave_a_r;
	logic        wave_b_r;
	logic        match_a_r;
	logic        match_b_r;
	logic        tick;
	logic        pin_event;
	logic        cap_event;
	logic [3:0]  waveform_mode_sel;
	logic [15:0] top;
	logic        top_is_cap;
	logic        pwm_mode;
	logic        ctc_mode;
	logic        normal_mode;
	logic        dual_slope;
	logic        cnt_wr;
	logic        at_top;
	logic        at_bottom;
	logic        ovf_evt;
	logic [15:0] counter_nxt;
	logic        force_a;
	logic        force_b;
	logic        hit_a;
	logic        hit_b;
	logic [7:0]  flag_clr;
	logic [7:0]  flag_set;
	logic [7:0]  rdata_nxt;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	assign waveform_mode_sel = {ctrl_b_r[4:3], ctrl_a_r[1:0]};
	always_comb begin
		top_is_cap = 1'b0;
		pwm_mode   = 1'b1;
		ctc_mode   = 1'b0;
		dual_slope = 1'b0;
		top        = TOP_MAX;
		unique case (waveform_mode_sel)
			4'h0: pwm_mode = 1'b0;
			4'h1: begin top = 16'h00FF; dual_slope = 1'b1; end
			4'h2: begin top = 16'h01FF; dual_slope = 1'b1; end
			4'h3: begin top = 16'h03FF; dual_slope = 1'b1; end
			4'h4: begin top = compare_value_a_r; pwm_mode = 1'b0; ctc_mode = 1'b1; end
			4'h5: top = 16'h00FF;
			4'h6: top = 16'h01FF;
			4'h7: top = 16'h03FF;
			4'h8, 4'hA: begin top = capture_value_r; top_is_cap = 1'b1; dual_slope = 1'b1; end
			4'h9, 4'hB: begin top = compare_value_a_r; dual_slope = 1'b1; end
			4'hC: begin top = capture_value_r; top_is_cap = 1'b1; pwm_mode = 1'b0; ctc_mode = 1'b1; end
			4'hD: pwm_mode = 1'b0;
			4'hE: begin top = capture_value_r; top_is_cap = 1'b1; end
			4'hF: top = compare_value_a_r;
		endcase
	end
	assign normal_mode = (waveform_mode_sel == 4'h0);

	tmr_clock_select u_clk_sel (
		.clk_in     (sys_clk_in),
		.rst_n_in   (rst_n_r),
		.ce_in      (ce_in),
		.sel_in     (ctrl_b_r[2:0]),
		.ext_pin_in (external_count_pin_in),
		.tick_out   (tick)
	);

	tmr_capture_filter u_cap (
		.clk_in        (sys_clk_in),
		.rst_n_in      (rst_n_r),
		.ce_in         (ce_in),
		.pin_in        (ctrl_a_r[6] ? comparator_in : capture_input_pin_in),
		.filter_en_in  (ctrl_b_r[CB_NOISE_BIT]),
		.rising_sel_in (ctrl_b_r[CB_EDGE_BIT]),
		.event_out     (pin_event)
	);
	assign cap_event = pin_event & ~top_is_cap;

	assign cnt_wr    = wr_in && (addr_in == ADDR_CNT_L);
	assign at_top    = (counter_value_r == top);
	assign at_bottom = (counter_value_r == 16'h0000);
	assign ovf_evt   = tick && ((normal_mode || ctc_mode) ? (counter_value_r == TOP_MAX) :
		dual_slope ? (at_bottom && !up_r) : at_top);
	always_comb begin
		counter_nxt = counter_value_r + 16'h0001;
		if (dual_slope) begin
			counter_nxt = up_r ? (at_top ? counter_value_r - 16'h0001 : counter_value_r + 16'h0001)
				: (at_bottom ? 16'h0001 : counter_value_r - 16'h0001);
		end else if (!normal_mode && at_top) begin
			counter_nxt = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			counter_value_r <= REG16_RESET;
			up_r            <= 1'b1;
			block_r         <= 1'b0;
		end else if (ce_in) begin
			if (cnt_wr) begin
				counter_value_r <= {temp_r, wdata_in};
				block_r         <= 1'b1;
			end else if (tick) begin
				counter_value_r <= counter_nxt;
				block_r         <= 1'b0;
				if (dual_slope && at_top) up_r <= 1'b0;
				else if (dual_slope && at_bottom) up_r <= 1'b1;
			end
		end
	end

	assign hit_a = tick && !block_r && (counter_value_r == compare_value_a_r);
	assign hit_b = tick && !block_r && (counter_value_r == compare_value_b_r);
	assign force_a = wr_in && (addr_in == ADDR_CTRL_C) && wdata_in[CC_FORCE_A_BIT] && !pwm_mode;
	assign force_b = wr_in && (addr_in == ADDR_CTRL_C) && wdata_in[CC_FORCE_B_BIT] && !pwm_mode;

	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			match_a_r <= 1'b0;
			match_b_r <= 1'b0;
		end else if (ce_in) begin
			match_a_r <= hit_a;
			match_b_r <= hit_b;
		end
	end

	// compare output actions from the non-PWM table; PWM shaping not modelled
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
		end else if (ce_in) begin
			if (hit_a || force_a) begin
				unique case (ctrl_a_r[7:6] & 2'h3)
					2'h0: wave_a_r <= wave_a_r;
					2'h1: wave_a_r <= ~wave_a_r;
					2'h2: wave_a_r <= 1'b0;
					2'h3: wave_a_r <= 1'b1;
				endcase
			end
			if (hit_b || force_b) begin
				unique case (ctrl_a_r[5:4])
					2'h0: wave_b_r <= wave_b_r;
					2'h1: wave_b_r <= ~wave_b_r;
					2'h2: wave_b_r <= 1'b0;
					2'h3: wave_b_r <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			capture_value_r <= REG16_RESET;
		end else if (ce_in) begin
			if (cap_event) begin
				capture_value_r <= counter_value_r;
			end else if (wr_in && addr_in == ADDR_CAP_L) begin
				capture_value_r <= {temp_r, wdata_in};
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_a_r          <= REG8_RESET;
			ctrl_b_r          <= REG8_RESET;
			compare_value_a_r <= REG16_RESET;
			compare_value_b_r <= REG16_RESET;
			mask_r            <= REG8_RESET;
			gie_r             <= 1'b0;
		end else if (ce_in && wr_in) begin
			unique case (addr_in)
				ADDR_CTRL_A: ctrl_a_r <= wdata_in;
				ADDR_CTRL_B: ctrl_b_r <= wdata_in & CTRL_B_WR_MASK;
				ADDR_CMPA_L: compare_value_a_r <= {temp_r, wdata_in};
				ADDR_CMPB_L: compare_value_b_r <= {temp_r, wdata_in};
				ADDR_MASK:   mask_r <= wdata_in & IRQ_USED_MASK;
				ADDR_GIE:    gie_r <= wdata_in[0];
				default: ;
			endcase
		end
	end

	// high-byte latch: written by high-byte writes, loaded by counter and capture low-byte reads
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			temp_r <= REG8_RESET;
		end else if (ce_in) begin
			if (wr_in && (addr_in == ADDR_CNT_H || addr_in == ADDR_CAP_H ||
				addr_in == ADDR_CMPA_H || addr_in == ADDR_CMPB_H)) begin
				temp_r <= wdata_in;
			end else if (rd_in && addr_in == ADDR_CNT_L) begin
				temp_r <= counter_value_r[15:8];
			end else if (rd_in && addr_in == ADDR_CAP_L) begin
				temp_r <= capture_value_r[15:8];
			end
		end
	end

	always_comb begin
		flag_set = 8'h00;
		flag_set[IRQ_CAP_BIT]  = cap_event || (top_is_cap && tick && at_top);
		flag_set[IRQ_CMPA_BIT] = match_a_r;
		flag_set[IRQ_CMPB_BIT] = match_b_r;
		flag_set[IRQ_OVF_BIT]  = ovf_evt;
		flag_clr = 8'h00;
		if (wr_in && addr_in == ADDR_FLAGS) flag_clr = wdata_in & IRQ_USED_MASK;
		if (wr_in && addr_in == ADDR_VEC_ACK) flag_clr = wdata_in & IRQ_USED_MASK;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			flags_r <= REG8_RESET;
		end else if (ce_in) begin
			flags_r <= ((flags_r & ~flag_clr) | flag_set) & IRQ_USED_MASK;
		end
	end

	always_comb begin
		unique case (addr_in)
			ADDR_CTRL_A: rdata_nxt = ctrl_a_r;
			ADDR_CTRL_B: rdata_nxt = ctrl_b_r;
			ADDR_CTRL_C: rdata_nxt = 8'h00;
			ADDR_CNT_L:  rdata_nxt = counter_value_r[7:0];
			ADDR_CAP_L:  rdata_nxt = capture_value_r[7:0];
			ADDR_CMPA_L: rdata_nxt = compare_value_a_r[7:0];
			ADDR_CMPA_H: rdata_nxt = compare_value_a_r[15:8];
			ADDR_CMPB_L: rdata_nxt = compare_value_b_r[7:0];
			ADDR_CMPB_H: rdata_nxt = compare_value_b_r[15:8];
			ADDR_CNT_H, ADDR_CAP_H: rdata_nxt = temp_r;
			ADDR_MASK:   rdata_nxt = mask_r;
			ADDR_FLAGS:  rdata_nxt = flags_r;
			ADDR_GIE:    rdata_nxt = {7'h00, gie_r};
			default:     rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata_out <= 8'h00;
		end else if (ce_in) begin
			rdata_out <= rd_in ? rdata_nxt : 8'h00;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			capture_irq_out     <= 1'b0;
			compare_a_irq_out   <= 1'b0;
			compare_b_irq_out   <= 1'b0;
			overflow_irq_out    <= 1'b0;
			wave_out_chan_a_out <= 1'b0;
			wave_out_chan_b_out <= 1'b0;
		end else if (ce_in) begin
			capture_irq_out     <= gie_r & mask_r[IRQ_CAP_BIT] & flags_r[IRQ_CAP_BIT];
			compare_b_irq_out   <= gie_r & mask_r[IRQ_CMPB_BIT] & flags_r[IRQ_CMPB_BIT];
			compare_a_irq_out   <= gie_r & mask_r[IRQ_CMPA_BIT] & flags_r[IRQ_CMPA_BIT];
			overflow_irq_out    <= gie_r & mask_r[IRQ_OVF_BIT] & flags_r[IRQ_OVF_BIT];
			wave_out_chan_a_out <= wave_a_r;
			wave_out_chan_b_out <= wave_b_r;
		end
	end
endmodule
`default_nettype wire

// ### bench/tmr_pins.sv
// far-side model driving the capture pin and the external count pin
`default_nettype none
module tmr_pins (
	input  wire logic clk_in,
	output var logic  cap_pin_out,
	output var logic  ext_pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cap_pin_out = 1'b0;
		ext_pin_out = 1'b0;
	end
	// hold the capture pin at one level for n cycles
	task automatic cap(input logic v, input int n);
		cap_pin_out <= v;
		repeat (n) @(posedge clk_in);
	endtask
	// n count-pin periods, each half four cycles so sampling never misses one
	task automatic ext(input int n);
		repeat (n) begin
			ext_pin_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			ext_pin_out <= 1'b0;
			repeat (4) @(posedge clk_in);
		end
	endtask
endmodule
`default_nettype wire

// ### bench/tmr_monitor.sv
// assertion checker on the ports of the capture/compare timer
`default_nettype none
module tmr_monitor
	import tmr_pkg::*;
(
	input wire logic       sys_clk_in,
	input wire logic       rst_n_in,
	input wire logic       ce_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic       capture_input_pin_in,
	input wire logic       comparator_in,
	input wire logic       external_count_pin_in,
	input wire logic       wave_out_chan_a_out,
	input wire logic       wave_out_chan_b_out,
	input wire logic       capture_irq_out,
	input wire logic       compare_a_irq_out,
	input wire logic       compare_b_irq_out,
	input wire logic       overflow_irq_out
);
	logic [7:0]  mask_r;
	logic        gie_r;
	logic [7:0]  hold_r;
	logic [15:0] cmpa_r;
	logic [7:0]  en1_r;
	logic [7:0]  en2_r;
	logic [7:0]  off_w;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// irq enable quiet for three cycles means its output must be low
	assign off_w = ~((mask_r & {8{gie_r}}) | en1_r | en2_r);
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mask_r <= 8'h00;
			gie_r <= 1'b0;
			hold_r <= 8'h00;
			cmpa_r <= 16'h0000;
			en1_r <= 8'h00;
			en2_r <= 8'h00;
		end else begin
			en1_r <= mask_r & {8{gie_r}};
			en2_r <= en1_r;
			if (wr_in && ce_in && addr_in == ADDR_MASK) mask_r <= wdata_in & IRQ_USED_MASK;
			if (wr_in && ce_in && addr_in == ADDR_GIE) gie_r <= wdata_in[0];
			if (wr_in && ce_in && addr_in inside {ADDR_CNT_H, ADDR_CAP_H, ADDR_CMPA_H, ADDR_CMPB_H}) hold_r <= wdata_in;
			if (wr_in && ce_in && addr_in == ADDR_CMPA_L) cmpa_r <= {hold_r, wdata_in};
		end
	end
	rdata_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data not zero outside a read");
	mask_read_a: assert property (rd_in && addr_in == ADDR_MASK |=> rdata_out == mask_r)
		else $error("mask read mismatch");
	flag_rsvd_a: assert property (rd_in && addr_in == ADDR_FLAGS |=> (rdata_out & ~IRQ_USED_MASK) == 8'h00)
		else $error("reserved flag bits not zero");
	force_zero_a: assert property (rd_in && addr_in == ADDR_CTRL_C |=> rdata_out == 8'h00)
		else $error("control C not zero");
	ctrlb_rsvd_a: assert property (rd_in && addr_in == ADDR_CTRL_B |=> !rdata_out[CB_RSVD_BIT])
		else $error("control B bit5 not zero");
	cmpa_low_a: assert property (rd_in && addr_in == ADDR_CMPA_L |=> rdata_out == cmpa_r[7:0])
		else $error("compare A low byte mismatch");
	cmpa_high_a: assert property (rd_in && addr_in == ADDR_CMPA_H |=> rdata_out == cmpa_r[15:8])
		else $error("compare A high byte mismatch");
	cap_irq_off_a: assert property (off_w[IRQ_CAP_BIT] |-> !capture_irq_out)
		else $error("capture irq while disabled");
	cmp_irq_off_a: assert property (off_w[IRQ_CMPA_BIT] && off_w[IRQ_CMPB_BIT] |-> !compare_a_irq_out && !compare_b_irq_out)
		else $error("compare irq while disabled");
	ovf_irq_off_a: assert property (off_w[IRQ_OVF_BIT] |-> !overflow_irq_out)
		else $error("overflow irq while disabled");
	cover property (capture_irq_out);
	cover property (overflow_irq_out);
	cover property ($changed(wave_out_chan_a_out));
endmodule
bind tmr_top tmr_monitor i_tmr_monitor (.*);
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the capture/compare timer
`default_nettype none
module testbench
	import tmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       sys_clk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       ce_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [7:0] wdata_in = 8'h00;
	logic       wr_in = 1'b0;
	logic       rd_in = 1'b0;
	logic       comparator_in = 1'b0;
	logic [7:0] rdata_out;
	logic       capture_input_pin_in;
	logic       external_count_pin_in;
	logic       wave_out_chan_a_out;
	logic       wave_out_chan_b_out;
	logic       capture_irq_out;
	logic       compare_a_irq_out;
	logic       compare_b_irq_out;
	logic       overflow_irq_out;
	int         err_count = 0;
	int         cmp_count = 0;
	always #4 sys_clk_in = ~sys_clk_in;
	tmr_top i_tmr_top (.*);
	tmr_pins i_tmr_pins (.clk_in(sys_clk_in), .cap_pin_out(capture_input_pin_in), .ext_pin_out(external_count_pin_in));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge sys_clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
		@(posedge sys_clk_in);
	endtask
	task automatic chkr(input string nm, input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(nm, 16'(exp), 16'(d));
	endtask
	task automatic wr16(input logic [3:0] ah, input logic [15:0] v);
		wr(ah, v[15:8]);
		wr(ah - 4'h1, v[7:0]);
	endtask
	task automatic rd16(input logic [3:0] al, output logic [15:0] v);
		rd(al, v[7:0]);
		rd(al + 4'h1, v[15:8]);
	endtask
	task automatic run(input logic [7:0] cb, input int n);
		wr(ADDR_CTRL_B, cb);
		repeat (n) @(posedge sys_clk_in);
		wr(ADDR_CTRL_B, 8'h00);
	endtask
	task automatic settle;
		repeat (3) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic t_regs;
		logic [15:0] v;
		wr(ADDR_MASK, 8'hFF);
		chkr("mask", ADDR_MASK, IRQ_USED_MASK);
		wr(ADDR_MASK, 8'h00);
		wr(ADDR_CTRL_B, 8'hDF);
		chkr("ctrl_b", ADDR_CTRL_B, 8'hDF);
		wr(ADDR_CTRL_B, 8'h00);
		wr(ADDR_CTRL_C, 8'hC0);
		chkr("ctrl_c", ADDR_CTRL_C, 8'h00);
		wr(ADDR_CNT_H, 8'h12);
		wr(ADDR_CMPA_H, 8'h77);
		wr(ADDR_CNT_L, 8'h34);
		rd16(ADDR_CNT_L, v);
		chk("shared_latch", 16'h7734, v);
		wr16(ADDR_CMPA_H, 16'hA55A);
		rd16(ADDR_CMPA_L, v);
		chk("cmp_a", 16'hA55A, v);
		wr(4'h3, 8'hFF);
		chkr("unmapped", 4'h3, 8'h00);
		wr16(ADDR_CMPA_H, 16'h0040);
		wr16(ADDR_CMPB_H, 16'h0050);
	endtask
	task automatic t_clk;
		int dv[6] = '{0, 1, 8, 64, 256, 1024};
		logic [15:0] v;
		for (int c = 0; c < 8; c++) begin
			wr16(ADDR_CNT_H, 16'h0000);
			if (c < 6) begin
				run(8'(c), 2048);
				rd16(ADDR_CNT_L, v);
				if (c == 0) chk("stopped", 16'h0000, v);
				else chk("prescaled", 16'h0001, 16'(v >= 2048 / dv[c] - 1 && v <= 2052 / dv[c] + 1));
			end else begin
				wr(ADDR_CTRL_B, 8'(c));
				i_tmr_pins.ext(5);
				run(8'h00, 8);
				rd16(ADDR_CNT_L, v);
				chk("ext_count", 16'h0005, v);
			end
		end
	endtask
	task automatic t_cmp;
		wr16(ADDR_CNT_H, 16'h0040);
		wr(ADDR_FLAGS, 8'h07);
		run(8'h01, 40);
		chkr("flags_blocked", ADDR_FLAGS, 8'h04);
		wr(ADDR_FLAGS, 8'h00);
		chkr("flags_zero_wr", ADDR_FLAGS, 8'h04);
		wr(ADDR_FLAGS, 8'h04);
		chkr("flags_clr", ADDR_FLAGS, 8'h00);
		wr(ADDR_MASK, 8'h06);
		wr(ADDR_GIE, 8'h01);
		wr16(ADDR_CNT_H, 16'h0030);
		run(8'h01, 40);
		chkr("flags_ab", ADDR_FLAGS, 8'h06);
		settle;
		chk("irq_ab", 16'h0003, 16'({compare_a_irq_out, compare_b_irq_out}));
		wr(ADDR_VEC_ACK, 8'h06);
		settle;
		chk("irq_ab_ack", 16'h0000, 16'({compare_a_irq_out, compare_b_irq_out}));
	endtask
	task automatic t_force;
		logic a0;
		logic b0;
		wr(ADDR_CTRL_A, 8'h50);
		settle;
		a0 = wave_out_chan_a_out;
		b0 = wave_out_chan_b_out;
		wr(ADDR_CTRL_C, 8'h80);
		settle;
		chk("force_a", 16'({~a0, b0}), 16'({wave_out_chan_a_out, wave_out_chan_b_out}));
		wr(ADDR_CTRL_C, 8'h40);
		settle;
		chk("force_b", 16'({~a0, ~b0}), 16'({wave_out_chan_a_out, wave_out_chan_b_out}));
		chk("irq_force", 16'h0000, 16'({compare_a_irq_out, compare_b_irq_out}));
		chkr("flags_force", ADDR_FLAGS, 8'h00);
		wr(ADDR_CTRL_A, 8'h51);
		wr(ADDR_CTRL_C, 8'h80);
		settle;
		chk("force_pwm", 16'({~a0, ~b0}), 16'({wave_out_chan_a_out, wave_out_chan_b_out}));
		wr(ADDR_CTRL_A, 8'h00);
	endtask
	task automatic t_cap;
		logic [15:0] v;
		wr16(ADDR_CNT_H, 16'h1234);
		wr(ADDR_MASK, 8'h20);
		wr(ADDR_CTRL_B, 8'h40);
		i_tmr_pins.cap(1'b1, 8);
		rd16(ADDR_CAP_L, v);
		chk("cap_rise", 16'h1234, v);
		settle;
		chk("cap_irq", 16'h0001, 16'(capture_irq_out));
		chkr("cap_flag", ADDR_FLAGS, 8'h20);
		wr(ADDR_VEC_ACK, 8'h20);
		i_tmr_pins.cap(1'b0, 8);
		chkr("no_fall", ADDR_FLAGS, 8'h00);
		wr(ADDR_CTRL_B, 8'h00);
		wr16(ADDR_CNT_H, 16'h2345);
		i_tmr_pins.cap(1'b1, 8);
		chkr("no_rise", ADDR_FLAGS, 8'h00);
		i_tmr_pins.cap(1'b0, 8);
		rd16(ADDR_CAP_L, v);
		chk("cap_fall", 16'h2345, v);
		wr(ADDR_FLAGS, 8'h20);
		wr(ADDR_CTRL_B, 8'hC0);
		wr16(ADDR_CNT_H, 16'h0777);
		i_tmr_pins.cap(1'b1, 2);
		i_tmr_pins.cap(1'b0, 8);
		chkr("glitch", ADDR_FLAGS, 8'h00);
		i_tmr_pins.cap(1'b1, 8);
		rd16(ADDR_CAP_L, v);
		chk("filtered", 16'h0777, v);
		wr(ADDR_FLAGS, 8'h20);
		wr(ADDR_CTRL_B, 8'hD8);
		wr16(ADDR_CNT_H, 16'h0999);
		i_tmr_pins.cap(1'b0, 8);
		i_tmr_pins.cap(1'b1, 8);
		rd16(ADDR_CAP_L, v);
		chk("cap_top", 16'h0777, v);
		chkr("cap_top_flag", ADDR_FLAGS, 8'h00);
		wr(ADDR_CTRL_B, 8'h00);
		wr16(ADDR_CNT_H, 16'h0770);
		run(8'hD9, 20);
		chkr("cap_top_reach", ADDR_FLAGS, 8'h20);
		wr(ADDR_FLAGS, 8'h20);
	endtask
	// a low clock enable must freeze the running counter
	task automatic t_ce;
		logic [15:0] v;
		wr16(ADDR_CNT_H, 16'h0000);
		wr(ADDR_CTRL_B, 8'h01);
		ce_in <= 1'b0;
		repeat (50) @(posedge sys_clk_in);
		ce_in <= 1'b1;
		wr(ADDR_CTRL_B, 8'h00);
		rd16(ADDR_CNT_L, v);
		chk("ce_freeze", 16'h0002, v);
	endtask
	task automatic t_ovf;
		wr(ADDR_MASK, 8'h00);
		wr16(ADDR_CNT_H, 16'hFFFA);
		run(8'h01, 20);
		chkr("ovf_flag", ADDR_FLAGS, 8'h01);
		settle;
		chk("ovf_masked", 16'h0000, 16'(overflow_irq_out));
		wr(ADDR_MASK, 8'h01);
		settle;
		chk("ovf_irq", 16'h0001, 16'(overflow_irq_out));
		wr(ADDR_GIE, 8'h00);
		settle;
		chk("ovf_gie_off", 16'h0000, 16'(overflow_irq_out));
		wr(ADDR_GIE, 8'h01);
		wr(ADDR_VEC_ACK, 8'h01);
		settle;
		chk("ovf_ack", 16'h0000, 16'(overflow_irq_out));
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		t_regs;
		t_clk;
		t_cmp;
		t_force;
		t_cap;
		t_ovf;
		t_ce;
		tally_and_finish;
	end
	initial begin
		repeat (40000) @(posedge sys_clk_in);
		err_count++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
